// ==== design/pld_pkg.sv ====
/*
  Constants, register map and types for the second-loop lock detector control block.
  Assumes a 40 MHz bus clock and phase error samples already taken into that domain.
*/
package pld_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_W = 9;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PD_CTRL = 9'h169;
  localparam logic [IDX_W-1:0] IDX_CNT_HI = 9'h16a;
  localparam logic [IDX_W-1:0] IDX_CNT_LO = 9'h16b;
  localparam logic [IDX_W-1:0] IDX_PIN_SEL = 9'h16e;
  localparam logic [IDX_W-1:0] IDX_STATUS = 9'h170;
  localparam logic [IDX_W-1:0] IDX_MASK = 9'h171;

  // ------------------------------------------------------------------
  // Reset values and writable bits
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h58;
  localparam logic [7:0] CNT_HI_RST = 8'h20;
  localparam logic [7:0] CNT_LO_RST = 8'h00;
  localparam logic [7:0] PIN_SEL_RST = 8'h06;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h7f;
  localparam logic [7:0] CNT_HI_WMASK = 8'h3f;
  localparam logic [7:0] MASK_WMASK = 8'h03;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HIZ_BIT = 1;
  localparam int CTRL_SLOPE_BIT = 2;
  localparam int CTRL_WIN_LSB = 5;
  localparam int CTRL_WIN_MSB = 6;
  localparam int CNT_HI_MSB = 5;
  localparam int SEL_LSB = 3;
  localparam int SEL_MSB = 7;
  localparam int CNT_W = 14;

  // ------------------------------------------------------------------
  // Selector codes and window sizes
  // ------------------------------------------------------------------
  localparam logic [4:0] SEL_LOW = 5'h00;
  localparam logic [4:0] SEL_OTHER = 5'h01;
  localparam logic [4:0] SEL_LOCK = 5'h02;
  localparam logic [4:0] SEL_BOTH = 5'h03;
  localparam logic [1:0] WIN_RSVD = 2'h0;
  localparam logic [1:0] WIN_1 = 2'h1;
  localparam logic [1:0] WIN_2 = 2'h2;
  localparam logic [1:0] WIN_3 = 2'h3;
  localparam logic [11:0] WIN_1_PS = 12'h3e8;
  localparam logic [11:0] WIN_2_PS = 12'h708;
  localparam logic [11:0] WIN_3_PS = 12'ha28;

  // ------------------------------------------------------------------
  // Status bits
  // ------------------------------------------------------------------
  localparam int ST_GAINED_BIT = 0;
  localparam int ST_LOST_BIT = 1;

  typedef enum logic [1:0] {
    PLD_WR_IDLE = 2'b01,
    PLD_WR_RESP = 2'b10
  } pld_wr_t;

endpackage

// ==== design/pld_qualify.sv ====
/*
  Lock qualification counter: counts consecutive in-window phase comparisons.
  Assumes one strobe per phase detector cycle, synchronous to clk.
*/
`timescale 1ns/100ps
module pld_qualify (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparison stream
  input wire logic enable,
  input wire logic strobe,
  input wire logic in_window,
  input wire logic [pld_pkg::CNT_W-1:0] target,
  // Result
  output logic locked
);
  import pld_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic locked;
  } pld_qual_st_t;

  pld_qual_st_t r_reg;
  pld_qual_st_t r_next;

  always_comb begin
    r_next = r_reg;
    if (!enable) begin
      r_next.cnt = '0;
      r_next.locked = 1'b0;
    end else if (strobe) begin
      if (!in_window) begin
        r_next.cnt = '0;
        r_next.locked = 1'b0;
      end else if (target != '0) begin
        if (r_reg.cnt < target) begin
          r_next.cnt = r_reg.cnt + 14'h1;
        end
        if (r_next.cnt >= target) begin
          r_next.locked = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign locked = r_reg.locked;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence miss_then_hit;
    (enable && strobe && !in_window) ##1 (enable && strobe && in_window && target > 14'h1);
  endsequence

  lock_needs_count_a: assert property ($rose(locked) |-> r_reg.cnt >= target)
    else $error("lock rose before the qualify count was reached");
  zero_target_a: assert property ((target == 14'h0) |=> !$rose(locked))
    else $error("lock declared with a zero qualify count");
  window_miss_a: assert property (
    (enable && strobe && !in_window) |=> !locked && r_reg.cnt == 14'h0)
    else $error("out-of-window comparison did not restart qualification");
  restart_hold_a: assert property (miss_then_hit |=> !locked)
    else $error("lock declared one comparison after a miss");
  detector_off_a: assert property (!enable |=> !locked && r_reg.cnt == 14'h0)
    else $error("disabled detector still counting or locked");

endmodule

// ==== design/pld_top.sv ====
/*
  Second-loop phase detector control, lock detector and status pin selector.
  Registers over AXI4-Lite; phase error samples arrive synchronous to aclk.
*/
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module pld_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [pld_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [pld_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Phase comparison input
  input wire logic pd_strobe,
  input wire logic [11:0] phase_err_ps,
  input wire logic other_lock_in,
  // Charge pump control
  output logic pump_slope_select,
  output logic pump_high_impedance,
  // Lock outputs
  output logic digital_lock_indication,
  output logic second_lock_status_pin,
  output logic irq
);
  import pld_pkg::*;

  typedef struct packed {
    pld_wr_t wr;
    logic aw_got;
    logic w_got;
    logic [IDX_W-1:0] aw_idx;
    logic [7:0] wdat;
    logic wstb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] cnt_hi;
    logic [7:0] cnt_lo;
    logic [7:0] pin_sel;
    logic [7:0] mask;
    logic [1:0] sticky;
    logic lock_d;
    logic pin;
    logic irq;
  } pld_top_st_t;

  localparam pld_top_st_t ST_RST = '{
    wr: PLD_WR_IDLE,
    aw_got: 1'b0,
    w_got: 1'b0,
    aw_idx: '0,
    wdat: 8'h00,
    wstb: 1'b0,
    awready: 1'b0,
    wready: 1'b0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    arready: 1'b0,
    rvalid: 1'b0,
    rresp: RESP_OKAY,
    rdata: 32'h0000_0000,
    ctrl: CTRL_RST,
    cnt_hi: CNT_HI_RST,
    cnt_lo: CNT_LO_RST,
    pin_sel: PIN_SEL_RST,
    mask: MASK_RST,
    sticky: 2'h0,
    lock_d: 1'b0,
    pin: 1'b0,
    irq: 1'b0
  };

  pld_top_st_t r_reg;
  pld_top_st_t r_next;

  logic lock_q;
  logic det_en;
  logic in_win;
  logic [11:0] window_ps;
  logic [4:0] sel;
  logic [CNT_W-1:0] target;
  logic [IDX_W-1:0] ar_idx;

  // ------------------------------------------------------------------
  // Detector configuration
  // ------------------------------------------------------------------
  always_comb begin
    sel = r_reg.pin_sel[SEL_MSB:SEL_LSB];
    target = {r_reg.cnt_hi[CNT_HI_MSB:0], r_reg.cnt_lo};
    ar_idx = s_axi_araddr[IDX_MSB:IDX_LSB];
    det_en = r_reg.ctrl[CTRL_EN_BIT];
    if (sel == SEL_LOCK || sel == SEL_BOTH) begin
      det_en = 1'b1;
    end
    case (r_reg.ctrl[CTRL_WIN_MSB:CTRL_WIN_LSB])
      WIN_1: window_ps = WIN_1_PS;
      WIN_2: window_ps = WIN_2_PS;
      WIN_3: window_ps = WIN_3_PS;
      default: window_ps = 12'h000;
    endcase
    // Reserved code never qualifies
    in_win = (r_reg.ctrl[CTRL_WIN_MSB:CTRL_WIN_LSB] != WIN_RSVD) && (phase_err_ps <= window_ps);
  end

  pld_qualify u_qualify (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(det_en),
    .strobe(pd_strobe),
    .in_window(in_win),
    .target(target),
    .locked(lock_q)
  );

  // ------------------------------------------------------------------
  // Bus slave, events and pin
  // ------------------------------------------------------------------
  always_comb begin
    logic clr_sticky;
    logic [1:0] set_ev;
    clr_sticky = 1'b0;
    set_ev = 2'h0;
    r_next = r_reg;
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.aw_idx = s_axi_awaddr[IDX_MSB:IDX_LSB];
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.wdat = s_axi_wdata[7:0];
      r_next.wstb = s_axi_wstrb[0];
    end
    case (r_reg.wr)
      PLD_WR_IDLE: begin
        if (r_next.aw_got && r_next.w_got) begin
          r_next.bresp = RESP_OKAY;
          case (r_next.aw_idx)
            IDX_PD_CTRL: begin
              if (r_next.wstb) begin
                r_next.ctrl = r_next.wdat & CTRL_WMASK;
              end
            end
            IDX_CNT_HI: begin
              if (r_next.wstb) begin
                r_next.cnt_hi = r_next.wdat & CNT_HI_WMASK;
              end
            end
            IDX_CNT_LO: begin
              if (r_next.wstb) begin
                r_next.cnt_lo = r_next.wdat;
              end
            end
            IDX_PIN_SEL: begin
              if (r_next.wstb) begin
                r_next.pin_sel = r_next.wdat;
              end
            end
            IDX_MASK: begin
              if (r_next.wstb) begin
                r_next.mask = r_next.wdat & MASK_WMASK;
              end
            end
            IDX_STATUS: begin
              r_next.bresp = RESP_OKAY;
            end
            default: begin
              r_next.bresp = RESP_SLVERR;
            end
          endcase
          r_next.aw_got = 1'b0;
          r_next.w_got = 1'b0;
          r_next.bvalid = 1'b1;
          r_next.wr = PLD_WR_RESP;
        end
      end
      PLD_WR_RESP: begin
        if (s_axi_bready) begin
          r_next.bvalid = 1'b0;
          r_next.wr = PLD_WR_IDLE;
        end
      end
      default: begin
        r_next.wr = PLD_WR_IDLE;
      end
    endcase
    r_next.awready = !r_next.aw_got && (r_next.wr == PLD_WR_IDLE);
    r_next.wready = !r_next.w_got && (r_next.wr == PLD_WR_IDLE);
    // Read path
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      r_next.rdata = 32'h0000_0000;
      case (ar_idx)
        IDX_PD_CTRL: r_next.rdata[7:0] = r_reg.ctrl;
        IDX_CNT_HI: r_next.rdata[7:0] = r_reg.cnt_hi;
        IDX_CNT_LO: r_next.rdata[7:0] = r_reg.cnt_lo;
        IDX_PIN_SEL: r_next.rdata[7:0] = r_reg.pin_sel;
        IDX_MASK: r_next.rdata[7:0] = r_reg.mask;
        IDX_STATUS: begin
          r_next.rdata[2:0] = {lock_q, r_reg.sticky};
          clr_sticky = 1'b1;
        end
        default: r_next.rresp = RESP_SLVERR;
      endcase
    end
    r_next.arready = !r_next.rvalid;
    // Sticky events, set wins over a clearing read
    r_next.lock_d = lock_q;
    set_ev[ST_GAINED_BIT] = lock_q && !r_reg.lock_d;
    set_ev[ST_LOST_BIT] = !lock_q && r_reg.lock_d;
    r_next.sticky = (clr_sticky ? 2'h0 : r_reg.sticky) | set_ev;
    r_next.irq = |(r_next.sticky & r_next.mask[1:0]);
    // Status pin source
    case (sel)
      SEL_LOW: r_next.pin = 1'b0;
      SEL_OTHER: r_next.pin = other_lock_in;
      SEL_LOCK: r_next.pin = lock_q;
      SEL_BOTH: r_next.pin = lock_q && other_lock_in;
      default: r_next.pin = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= ST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rvalid = r_reg.rvalid;
  assign pump_slope_select = r_reg.ctrl[CTRL_SLOPE_BIT];
  assign pump_high_impedance = r_reg.ctrl[CTRL_HIZ_BIT];
  assign digital_lock_indication = lock_q;
  assign second_lock_status_pin = r_reg.pin;
  assign irq = r_reg.irq;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [1:0] win_code;
  logic judged;
  assign win_code = r_reg.ctrl[CTRL_WIN_MSB:CTRL_WIN_LSB];
  assign judged = det_en && pd_strobe;

  sequence ctrl_write_done;
    $rose(r_reg.bvalid) && r_reg.aw_idx == IDX_PD_CTRL && r_reg.wstb;
  endsequence

  sequence one_hit_qualify;
    pd_strobe && in_win && target == 14'h1 && !lock_q;
  endsequence

  sequence write_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  slope_written_a: assert property (
    ctrl_write_done |-> pump_slope_select == r_reg.wdat[CTRL_SLOPE_BIT])
    else $error("slope output does not follow written value");
  hiz_written_a: assert property (
    ctrl_write_done |-> pump_high_impedance == r_reg.wdat[CTRL_HIZ_BIT])
    else $error("high impedance output does not follow written value");
  pin_route_en_a: assert property (
    (one_hit_qualify ##0 (sel == SEL_LOCK && !r_reg.ctrl[CTRL_EN_BIT]))
    |=> lock_q ##1 second_lock_status_pin)
    else $error("routing lock to pin did not enable the detector");
  spi_enable_a: assert property (
    (one_hit_qualify ##0 (sel == SEL_LOW && r_reg.ctrl[CTRL_EN_BIT]))
    |=> lock_q ##1 !second_lock_status_pin)
    else $error("enable bit did not run detector without pin");
  pin_follow_a: assert property (
    ($past(sel) == SEL_LOCK) |-> second_lock_status_pin == $past(lock_q))
    else $error("status pin does not follow lock");
  narrow_window_a: assert property (
    (judged && win_code == WIN_1 && phase_err_ps > WIN_1_PS) |=> !lock_q)
    else $error("error beyond 1 ns window kept lock");
  wide_window_a: assert property (
    (judged && win_code == WIN_3 && phase_err_ps > WIN_3_PS) |=> !lock_q)
    else $error("error beyond 2.6 ns window kept lock");
  reserved_window_a: assert property (
    (judged && win_code == WIN_RSVD) |=> !lock_q)
    else $error("reserved window code qualified a comparison");
  zero_count_a: assert property ((target == '0 && !lock_q) |=> !lock_q)
    else $error("lock rose while the qualify count was zero");
  irq_on_gain_a: assert property (($rose(lock_q) && r_reg.mask[ST_GAINED_BIT]) |=> irq)
    else $error("unmasked lock gain raised no interrupt");
  gain_sticky_a: assert property ($rose(lock_q) |=> r_reg.sticky[ST_GAINED_BIT])
    else $error("lock gain did not set its status bit");
  loss_sticky_a: assert property ($fell(lock_q) |=> r_reg.sticky[ST_LOST_BIT])
    else $error("lock loss did not set its status bit");
  irq_level_a: assert property (irq == |(r_reg.sticky & r_reg.mask[ST_LOST_BIT:ST_GAINED_BIT]))
    else $error("interrupt does not match unmasked status");
  unmapped_read_a: assert property (
    (s_axi_arvalid && s_axi_arready && ar_idx == 9'h000) |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not answered with error");
  write_answer_a: assert property (write_both_taken |=> s_axi_bvalid)
    else $error("write taken but no response raised");
  read_answer_a: assert property (read_taken |=> s_axi_rvalid)
    else $error("read taken but no data returned");
  bresp_hold_a: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  rdata_hold_a: assert property (
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while a response is pending");
  one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted while data is pending");

endmodule

// ==== testbench/tb.sv ====
/*
  Self-checking bench for the second-loop lock detector control block.
  Assumes pld_pkg and pld_top are compiled first; no partner model.
*/
`timescale 1ns/100ps
module tb;
  import pld_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic pd_strobe, other_lock_in, slope, hiz, lock, pin, irq, o;
  logic [11:0] phase_err_ps;
  int fails, compares, seed, c, e;

  pld_top i_pld_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pd_strobe(pd_strobe), .phase_err_ps(phase_err_ps), .other_lock_in(other_lock_in),
    .pump_slope_select(slope), .pump_high_impedance(hiz),
    .digital_lock_indication(lock), .second_lock_status_pin(pin), .irq(irq)
  );

  // ------------------------------------------------------------------
  // Expectations and checks
  // ------------------------------------------------------------------
  function automatic logic [11:0] lim(input int code);
    return code == 1 ? 12'h3e8 : code == 2 ? 12'h708 : code == 3 ? 12'ha28 : 12'h000;
  endfunction

  function automatic logic in_win(input int code, input logic [11:0] err);
    return code != 0 && err <= lim(code);
  endfunction

  function automatic logic pin_of(input int code, input logic lk, input logic ot);
    case (code)
      1: return ot;
      2: return lk;
      3: return lk & ot;
      default: return 1'b0;
    endcase
  endfunction

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic ex, input logic got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, ex, got);
    end
  endtask

  task automatic tmo();
    fails++;
    $display("ERROR handshake expected answer seen timeout");
    give_verdict();
  endtask

  // ------------------------------------------------------------------
  // Bus and stimulus tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v, output logic [1:0] rs);
    bit a, w, b;
    a = 0;
    w = 0;
    b = 0;
    @(posedge aclk);
    awaddr <= {1'b0, idx, 2'h0};
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 50 && !(a && w); n++) begin
      @(posedge aclk);
      if (!a && awready === 1'b1) begin
        a = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    if (!(a && w)) tmo();
    bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge aclk);
      if (bvalid === 1'b1) begin
        b = 1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
    if (!b) tmo();
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] v, output logic [1:0] rs);
    bit a, b;
    a = 0;
    b = 0;
    @(posedge aclk);
    araddr <= {1'b0, idx, 2'h0};
    arvalid <= 1'b1;
    for (int n = 0; n < 50 && !a; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) begin
        a = 1;
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
    end
    if (!a) tmo();
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) begin
        b = 1;
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
    if (!b) tmo();
  endtask

  task automatic wrc(input logic [IDX_W-1:0] idx, input logic [7:0] v);
    wr(idx, v, r);
    chk_word("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [7:0] ex);
    rd(idx, d, r);
    chk_word("rdata", {24'h0, ex}, d);
    chk_word("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // Back-to-back comparisons, then a settling gap
  task automatic strobes(input int n, input logic [11:0] err);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      pd_strobe <= 1'b1;
      phase_err_ps <= err;
    end
    @(posedge aclk);
    pd_strobe <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // One out-of-window comparison straight before n in-window ones
  task automatic miss_hit(input int n, input logic [11:0] err);
    @(posedge aclk);
    pd_strobe <= 1'b1;
    phase_err_ps <= 12'hfff;
    strobes(n, err);
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready} = '0;
    {arvalid, rready, pd_strobe, other_lock_in, phase_err_ps} = '0;
    seed = $urandom(32'hbc447299);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk_bit("slope", 1'b0, slope);
    chk_bit("lock", 1'b0, lock);
    rdc(IDX_PD_CTRL, CTRL_RST);
    rdc(IDX_CNT_HI, 8'h20);
    rdc(IDX_CNT_LO, 8'h00);
    rdc(IDX_PIN_SEL, 8'h06);
    rdc(IDX_MASK, 8'h00);
    rdc(IDX_STATUS, 8'h00);
    rd(9'h000, d, r);
    chk_word("rdata", 32'h0, d);
    chk_word("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(9'h100, 8'hff, r);
    chk_word("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wrc(IDX_PD_CTRL, 8'hff);
    rdc(IDX_PD_CTRL, 8'h7f);
    wrc(IDX_CNT_HI, 8'hff);
    rdc(IDX_CNT_HI, 8'h3f);
    wrc(IDX_MASK, 8'hff);
    rdc(IDX_MASK, 8'h03);
    wrc(IDX_MASK, 8'h00);
    for (c = 0; c < 4; c++) begin
      wrc(IDX_PD_CTRL, 8'h40 | 8'(c << 1));
      repeat (2) @(posedge aclk);
      chk_bit("slope", c[1], slope);
      chk_bit("hiz", c[0], hiz);
    end
    wrc(IDX_CNT_HI, 8'h00);
    wrc(IDX_CNT_LO, 8'h02);
    for (c = 0; c < 4; c++) begin
      wrc(IDX_PD_CTRL, {1'b0, 2'(c), 5'h01});
      strobes(1, 12'hfff);
      strobes(2, lim(c));
      chk_bit("lock", in_win(c, lim(c)), lock);
      strobes(1, lim(c) + 12'h001);
      chk_bit("lock", 1'b0, lock);
      strobes(1, 12'h000);
      chk_bit("lock", 1'b0, lock);
      miss_hit(1, lim(c));
      chk_bit("lock", 1'b0, lock);
      repeat (4) begin
        e = $urandom_range(4095);
        strobes(1, 12'hfff);
        strobes(2, 12'(e));
        chk_bit("lock", in_win(c, 12'(e)), lock);
      end
    end
    wrc(IDX_PD_CTRL, 8'h21);
    wrc(IDX_CNT_HI, 8'h01);
    wrc(IDX_CNT_LO, 8'h03);
    strobes(1, 12'hfff);
    strobes(258, 12'h000);
    chk_bit("lock", 1'b0, lock);
    strobes(1, 12'h3e8);
    chk_bit("lock", 1'b1, lock);
    wrc(IDX_CNT_HI, 8'h00);
    wrc(IDX_CNT_LO, 8'h00);
    strobes(1, 12'hfff);
    strobes(6, 12'h000);
    chk_bit("lock", 1'b0, lock);
    wrc(IDX_CNT_LO, 8'h01);
    wrc(IDX_PD_CTRL, 8'h20);
    strobes(2, 12'h000);
    chk_bit("lock", 1'b0, lock);
    wrc(IDX_PIN_SEL, 8'h16);
    strobes(2, 12'h000);
    chk_bit("lock", 1'b1, lock);
    chk_bit("pin", 1'b1, pin);
    wrc(IDX_PD_CTRL, 8'h21);
    wrc(IDX_PIN_SEL, 8'h06);
    strobes(1, 12'hfff);
    chk_bit("lock", 1'b0, lock);
    strobes(1, 12'h000);
    chk_bit("lock", 1'b1, lock);
    chk_bit("pin", 1'b0, pin);
    for (e = 1; e >= 0; e--) begin
      for (c = 0; c < 32; c++) begin
        wrc(IDX_PIN_SEL, {5'(c), 3'h6});
        repeat (2) begin
          @(posedge aclk);
          o = 1'($urandom_range(1));
          other_lock_in <= o;
          repeat (4) @(posedge aclk);
          chk_bit("pin", pin_of(c, e[0], o), pin);
        end
      end
      strobes(1, 12'hfff);
    end
    wrc(IDX_PIN_SEL, 8'h06);
    rd(IDX_STATUS, d, r);
    wrc(IDX_MASK, 8'h01);
    strobes(2, 12'h000);
    chk_bit("irq", 1'b1, irq);
    rdc(IDX_STATUS, 8'h05);
    repeat (3) @(posedge aclk);
    chk_bit("irq", 1'b0, irq);
    wrc(IDX_MASK, 8'h02);
    strobes(1, 12'hfff);
    chk_bit("irq", 1'b1, irq);
    rdc(IDX_STATUS, 8'h02);
    repeat (3) @(posedge aclk);
    chk_bit("irq", 1'b0, irq);
    wrc(IDX_MASK, 8'h00);
    strobes(2, 12'h000);
    chk_bit("irq", 1'b0, irq);
    rdc(IDX_STATUS, 8'h05);
    give_verdict();
  end
endmodule
